// File: verilog/wdtm_pkg.sv
// wdtm_pkg: constants, register map and carrier types for the watchdog timer
// assumes a 125 MHz pclk and a 32-bit APB register bus
package wdtm_pkg;

	// ----------------------------------------
	// clock and time base
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 125_000_000; // pclk rate
	localparam int unsigned LF_OSC_HZ = 31_000; // low_freq_osc nominal rate
	localparam int unsigned LF_TICK_CYCLES = CLK_HZ / LF_OSC_HZ; // pclk cycles per osc period
	localparam int unsigned COUNT_W = 23; // widest prescale is two to the 23rd
	localparam int unsigned MIN_SHIFT = 5; // minimum prescale 1:32

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h00; // watchdog_control
	localparam logic [7:0] ADDR_STATUS = 8'h04; // flags and live state
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08; // sticky events, write one to clear
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C; // event mask
	localparam logic [7:0] ADDR_COUNT = 8'h10; // live count

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int unsigned CTL_EN_BIT = 0; // soft_wdt_enable
	localparam int unsigned CTL_PS_LSB = 1; // period_select lsb
	localparam logic [4:0] PS_RESET = 5'h0B; // 1:65536, about 2 s
	localparam logic [4:0] PS_MAX = 5'h12; // largest defined code
	localparam logic CTL_EN_RESET = 1'h0;
	localparam int unsigned ST_TO_BIT = 0; // timeout_flag_n
	localparam int unsigned ST_PD_BIT = 1; // powerdown_flag_n
	localparam int unsigned ST_RW_BIT = 2; // wdt_reset_flag_n
	localparam int unsigned ST_ACT_BIT = 3; // watchdog active
	localparam int unsigned ST_SLP_BIT = 4; // device asleep
	localparam int unsigned EVT_RESET = 0; // time-out while awake
	localparam int unsigned EVT_WAKE = 1; // time-out while asleep
	localparam int unsigned EVT_OSCF = 2; // oscillator failure
	localparam int unsigned EVT_W = 3;
	localparam logic [2:0] MASK_RESET = 3'h0;

	// ----------------------------------------
	// enable modes of wdt_mode_select
	// ----------------------------------------
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SOFT = 2'h1;
	localparam logic [1:0] MODE_AWAKE = 2'h2;
	localparam logic [1:0] MODE_ON = 2'h3;

	// software control fields of watchdog_control
	typedef struct packed {
		logic [4:0] period_select;
		logic soft_wdt_enable;
	} wdtm_ctrl_type;

	// active-low status flags
	typedef struct packed {
		logic wdt_reset_flag_n;
		logic powerdown_flag_n;
		logic timeout_flag_n;
	} wdtm_flags_type;

endpackage : wdtm_pkg

// File: verilog/wdtm_sync.sv
// wdtm_sync: two flip-flop synchroniser for levels entering the pclk domain
// assumes inputs are slow levels; only the second stage is read outside
`timescale 1ns/1ns
module wdtm_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ----------------------------------------
	// two stage capture
	// ----------------------------------------
	logic [WIDTH-1:0] meta_r; // first stage, read only by sync_out

	// first stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
		end else begin
			meta_r <= async_in;
		end
	end

	// second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_out <= '0;
		end else begin
			sync_out <= meta_r;
		end
	end

endmodule : wdtm_sync

// File: verilog/wdtm_counter.sv
// wdtm_counter: watchdog count in low-frequency osc periods with time-out pulse
// assumes tick is a one-cycle enable at the osc rate and terminal is stable
`timescale 1ns/1ns
module wdtm_counter
	import wdtm_pkg::*;
#(
	parameter int unsigned WIDTH = COUNT_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic enable,
	input wire logic tick,
	input wire logic [WIDTH-1:0] terminal,
	output logic [WIDTH-1:0] count,
	output logic timeout
);

	// ----------------------------------------
	// count and terminal detection
	// ----------------------------------------
	logic hit; // count at terminal on a tick

	assign hit = enable && tick && (count == terminal);

	// count register, clear has priority
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (clear || !enable) begin
			count <= '0;
		end else if (hit) begin
			count <= '0;
		end else if (tick) begin
			count <= count + WIDTH'(1);
		end
	end

	// one pclk pulse per time-out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout <= 1'b0;
		end else begin
			timeout <= hit && !clear;
		end
	end

endmodule : wdtm_counter

// File: verilog/wdtm_top.sv
// wdtm_top: watchdog timer with APB registers, sleep handling and status flags
// assumes core signals share pclk; osc_fail arrives asynchronously from a pin
//
// Summary of operation
// - awake time-out requests a device reset
// - time base is low-frequency oscillator, about 32 us
// - two-bit mode field; 00 means always off
// - mode 11 always active, even in Sleep
// - mode 10 active awake, off in Sleep
// - mode 01 follows the software enable bit
// - software mode unaffected by Sleep transitions
// - period is 32 times two to code
// - reserved codes give the 1:32 interval
// - period resets to the 1:65536 code
// - count cleared on reset, clear, sleep, failure, disable
// - oscillator divider change leaves count alone
// - sleep entry clears, counting restarts, exit clears
// - sleep time-out wakes device, updates flags
// - watchdog-reset flag records the event, active low
// - wake clears count, clears timeout, clears powerdown
`timescale 1ns/1ns
module wdtm_top
	import wdtm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = LF_TICK_CYCLES,
	parameter int unsigned CNT_W = COUNT_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] wdt_mode_select,
	input wire logic wdt_clear_instruction,
	input wire logic sleep_active,
	input wire logic osc_fail,
	output logic wdt_reset_req,
	output logic wake_req,
	output logic timeout_flag_n,
	output logic powerdown_flag_n,
	output logic wdt_reset_flag_n,
	output logic irq
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	generate
		if (TICK_CYCLES < 1 || TICK_CYCLES > 4096) begin : g_bad_tick
			$error("TICK_CYCLES must fit the 12-bit divider");
		end
		if (CNT_W < COUNT_W || CNT_W > 32) begin : g_bad_width
			$error("CNT_W must cover the longest period and fit a bus word");
		end
	endgenerate

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------

	// terminal count for a period code, reserved codes fall to 1:32
	function automatic logic [CNT_W-1:0] period_terminal(input logic [4:0] code);
		logic [CNT_W-1:0] t;
		int unsigned shift;
		t = '0;
		shift = (code > PS_MAX) ? MIN_SHIFT : MIN_SHIFT + int'(code);
		for (int i = 0; i < CNT_W; i++) begin
			t[i] = (i < shift);
		end
		return t;
	endfunction : period_terminal

	// watchdog enable from mode, software bit and sleep state
	function automatic logic mode_active(input logic [1:0] mode, input logic sw_en, input logic asleep);
		logic a;
		a = 1'b0;
		unique case (mode)
			MODE_ON: begin
				a = 1'b1;
			end
			MODE_AWAKE: begin
				a = !asleep;
			end
			MODE_SOFT: begin
				a = sw_en;
			end
			MODE_OFF: begin
				a = 1'b0;
			end
		endcase
		return a;
	endfunction : mode_active

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	wdtm_ctrl_type ctrl_r; // software control fields
	wdtm_flags_type flags_r; // active-low status flags
	logic [EVT_W-1:0] evt_r; // sticky events
	logic [EVT_W-1:0] mask_r; // event mask
	logic [11:0] div_r; // osc period divider
	logic tick_r; // one pulse per osc period
	logic sleep_q_r; // previous sleep level
	logic osc_fail_s; // synchronised failure level
	logic osc_fail_q_r; // previous failure level
	logic sleep_enter; // sleep rising edge
	logic sleep_exit; // sleep falling edge
	logic active; // watchdog running
	logic active_r; // registered running state
	logic cnt_clear; // count clear request
	logic [CNT_W-1:0] count; // live count
	logic timeout_p; // time-out pulse from counter
	logic timeout_q_r; // retimed time-out
	logic timeout_sleep_r; // time-out came while asleep
	logic apb_setup; // setup phase
	logic apb_wr; // write taken this edge
	logic [EVT_W-1:0] evt_set; // events this cycle
	logic [31:0] rdata_nxt; // read mux
	logic addr_ok; // address decodes

	// ----------------------------------------
	// low-frequency time base
	// ----------------------------------------

	// divide pclk down to the osc period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else if (div_r == 12'(TICK_CYCLES - 1)) begin
			div_r <= '0;
			tick_r <= 1'b1;
		end else begin
			div_r <= div_r + 12'h001;
			tick_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// sleep and failure edges
	// ----------------------------------------
	wdtm_sync #(
		.WIDTH(1)
	) u_osc_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(osc_fail),
		.sync_out(osc_fail_s)
	);

	// previous levels for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_q_r <= 1'b0;
			osc_fail_q_r <= 1'b0;
		end else begin
			sleep_q_r <= sleep_active;
			osc_fail_q_r <= osc_fail_s;
		end
	end

	assign sleep_enter = sleep_active && !sleep_q_r;
	assign sleep_exit = !sleep_active && sleep_q_r;

	// ----------------------------------------
	// enable and count
	// ----------------------------------------
	assign active = mode_active(wdt_mode_select, ctrl_r.soft_wdt_enable, sleep_active);

	// count clears; the osc divider select has no path here
	assign cnt_clear = wdt_clear_instruction
		|| sleep_enter || sleep_exit
		|| osc_fail_s
		|| !active;

	wdtm_counter #(
		.WIDTH(CNT_W)
	) u_counter (
		.pclk(pclk),
		.presetn(presetn),
		.clear(cnt_clear),
		.enable(active),
		.tick(tick_r),
		.terminal(period_terminal(ctrl_r.period_select)),
		.count(count),
		.timeout(timeout_p)
	);

	// retime the time-out and note the sleep state at that moment
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_q_r <= 1'b0;
			timeout_sleep_r <= 1'b0;
			active_r <= 1'b0;
		end else begin
			timeout_q_r <= timeout_p;
			timeout_sleep_r <= sleep_active;
			active_r <= active;
		end
	end

	// ----------------------------------------
	// reset and wake requests
	// ----------------------------------------

	// awake time-out resets, sleeping time-out wakes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_reset_req <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			wdt_reset_req <= timeout_q_r && !timeout_sleep_r;
			wake_req <= timeout_q_r && timeout_sleep_r;
		end
	end

	// ----------------------------------------
	// status flags
	// ----------------------------------------

	// all flags in one process so the struct has a single driver
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r.timeout_flag_n <= 1'b1;
			flags_r.powerdown_flag_n <= 1'b1;
			flags_r.wdt_reset_flag_n <= 1'b1;
		end else begin
			// time-out wins over other updates
			if (timeout_q_r) begin
				flags_r.timeout_flag_n <= 1'b0;
				flags_r.powerdown_flag_n <= !timeout_sleep_r;
			end else if (sleep_enter) begin
				flags_r.timeout_flag_n <= 1'b1;
				flags_r.powerdown_flag_n <= 1'b0;
			end else if (wdt_clear_instruction) begin
				flags_r.timeout_flag_n <= 1'b1;
				flags_r.powerdown_flag_n <= 1'b1;
			end
			// watchdog-reset event wins over software set
			if (timeout_q_r && !timeout_sleep_r) begin
				flags_r.wdt_reset_flag_n <= 1'b0;
			end else if (apb_wr && paddr == ADDR_STATUS && pwdata[ST_RW_BIT]) begin
				flags_r.wdt_reset_flag_n <= 1'b1;
			end
		end
	end

	// flag outputs straight from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_flag_n <= 1'b1;
			powerdown_flag_n <= 1'b1;
			wdt_reset_flag_n <= 1'b1;
		end else begin
			timeout_flag_n <= flags_r.timeout_flag_n;
			powerdown_flag_n <= flags_r.powerdown_flag_n;
			wdt_reset_flag_n <= flags_r.wdt_reset_flag_n;
		end
	end

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pready && pwrite;

	// address decode
	always_comb begin
		addr_ok = 1'b1;
		rdata_nxt = '0;
		unique case (paddr)
			ADDR_CONTROL: begin
				rdata_nxt[CTL_EN_BIT] = ctrl_r.soft_wdt_enable;
				rdata_nxt[CTL_PS_LSB +: 5] = ctrl_r.period_select;
			end
			ADDR_STATUS: begin
				rdata_nxt[ST_TO_BIT] = flags_r.timeout_flag_n;
				rdata_nxt[ST_PD_BIT] = flags_r.powerdown_flag_n;
				rdata_nxt[ST_RW_BIT] = flags_r.wdt_reset_flag_n;
				rdata_nxt[ST_ACT_BIT] = active_r;
				rdata_nxt[ST_SLP_BIT] = sleep_q_r;
			end
			ADDR_IRQ_STATUS: begin
				rdata_nxt[EVT_W-1:0] = evt_r;
			end
			ADDR_IRQ_MASK: begin
				rdata_nxt[EVT_W-1:0] = mask_r;
			end
			ADDR_COUNT: begin
				rdata_nxt[CNT_W-1:0] = count;
			end
			default: begin
				addr_ok = 1'b0; // unmapped
			end
		endcase
	end

	// one wait-free access phase; data and error caught at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (apb_setup) begin
			pready <= 1'b1;
			pslverr <= !addr_ok;
			prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
	end

	// control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r.period_select <= PS_RESET;
			ctrl_r.soft_wdt_enable <= CTL_EN_RESET;
		end else if (apb_wr && paddr == ADDR_CONTROL) begin
			ctrl_r.period_select <= pwdata[CTL_PS_LSB +: 5];
			ctrl_r.soft_wdt_enable <= pwdata[CTL_EN_BIT];
		end
	end

	// mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= MASK_RESET;
		end else if (apb_wr && paddr == ADDR_IRQ_MASK) begin
			mask_r <= pwdata[EVT_W-1:0];
		end
	end

	// ----------------------------------------
	// interrupt events
	// ----------------------------------------
	assign evt_set[EVT_RESET] = timeout_q_r && !timeout_sleep_r;
	assign evt_set[EVT_WAKE] = timeout_q_r && timeout_sleep_r;
	assign evt_set[EVT_OSCF] = osc_fail_s && !osc_fail_q_r;

	// sticky events, set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_r <= '0;
		end else if (apb_wr && paddr == ADDR_IRQ_STATUS) begin
			evt_r <= (evt_r & ~pwdata[EVT_W-1:0]) | evt_set;
		end else begin
			evt_r <= evt_r | evt_set;
		end
	end

	// level interrupt from unmasked events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(evt_r & mask_r);
		end
	end

endmodule : wdtm_top

// File: tb/wdtm_properties.sv
// wdtm_properties: concurrent checks on the watchdog top ports
// assumes a bind onto wdtm_top, pclk with active-low presetn
`timescale 1ns/1ns
module wdtm_properties
	import wdtm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] wdt_mode_select,
	input wire logic sleep_active,
	input wire logic wdt_reset_req,
	input wire logic wake_req,
	input wire logic timeout_flag_n,
	input wire logic powerdown_flag_n,
	input wire logic wdt_reset_flag_n
);
	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	access_answer_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	unmapped_err_a: assert property (psel && !penable && paddr > ADDR_COUNT |=> pslverr && pready && prdata == 32'h0)
		else $error("unmapped access not refused");
	// ----------------------------------------
	// requests and flags
	// ----------------------------------------
	req_pulse_a: assert property (wdt_reset_req || wake_req |=> !(wdt_reset_req || wake_req))
		else $error("request longer than one cycle");
	mode_off_a: assert property ((wdt_mode_select == MODE_OFF) [*5] |-> !wdt_reset_req && !wake_req)
		else $error("request while mode is off");
	awake_only_a: assert property ((wdt_mode_select == MODE_AWAKE && sleep_active) [*5] |-> !wake_req)
		else $error("wake in awake-only mode");
	sleep_noreset_a: assert property (sleep_active [*4] |-> !wdt_reset_req)
		else $error("reset request while asleep");
	reset_flag_a: assert property (wdt_reset_req |=> !wdt_reset_flag_n)
		else $error("reset flag not recorded");
	timeout_flag_a: assert property (wdt_reset_req || wake_req |=> !timeout_flag_n)
		else $error("timeout flag not cleared");
	wake_flags_a: assert property (wake_req |=> !powerdown_flag_n)
		else $error("powerdown flag wrong after wake");
	cover property (wdt_reset_req);
	cover property (wake_req);
	cover property (pslverr);
endmodule : wdtm_properties

// File: tb/wdtm_core_model.sv
// wdtm_core_model: stand-in for the processor core beside the watchdog
// assumes the bench asks for clears and sleep with one-cycle commands
`timescale 1ns/1ns
module wdtm_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr_cmd,
	input wire logic sleep_cmd,
	input wire logic wake_req,
	output logic wdt_clear_instruction,
	output logic sleep_active
);
	// clear instruction sent as a one-cycle request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_clear_instruction <= 1'h0;
		end else begin
			wdt_clear_instruction <= clr_cmd && !wdt_clear_instruction;
		end
	end
	// asleep until the watchdog wakes the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_active <= 1'h0;
		end else if (wake_req) begin
			sleep_active <= 1'h0;
		end else if (sleep_cmd) begin
			sleep_active <= 1'h1;
		end
	end
endmodule : wdtm_core_model

// File: tb/tb.sv
// tb: self-checking bench for the watchdog top
// assumes a short tick parameter and the core model driving clear and sleep
`timescale 1ns/1ns
module tb
	import wdtm_pkg::*;
;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic osc_fail = 0;
	logic clr_cmd = 0;
	logic sleep_cmd = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [1:0] wdt_mode_select = MODE_OFF;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, wdt_clear_instruction, sleep_active, wdt_reset_req, wake_req;
	logic timeout_flag_n, powerdown_flag_n, wdt_reset_flag_n, irq;
	int errors = 0;
	int n_compared = 0;
	// 125 MHz clock
	always #4 pclk = ~pclk;
	wdtm_top #(.TICK_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wdt_mode_select(wdt_mode_select), .wdt_clear_instruction(wdt_clear_instruction),
		.sleep_active(sleep_active), .osc_fail(osc_fail), .wdt_reset_req(wdt_reset_req), .wake_req(wake_req),
		.timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
		.wdt_reset_flag_n(wdt_reset_flag_n), .irq(irq));
	wdtm_core_model u_core (.pclk(pclk), .presetn(presetn), .clr_cmd(clr_cmd), .sleep_cmd(sleep_cmd),
		.wake_req(wake_req), .wdt_clear_instruction(wdt_clear_instruction), .sleep_active(sleep_active));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic close_out();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out
	// one apb transfer, then one idle cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
		if (n >= 16) begin
			errors++;
			close_out();
		end
	endtask : apb
	// one-cycle command to the core model
	task automatic kick(input logic slp);
		if (slp) begin
			sleep_cmd <= 1'h1;
		end else begin
			clr_cmd <= 1'h1;
		end
		@(posedge pclk);
		sleep_cmd <= 1'h0;
		clr_cmd <= 1'h0;
	endtask : kick
	// watch for a request: 0 none, 1 reset, 2 wake; it must not come before lo
	task automatic run(input int ev, input int lo, input int hi);
		int n;
		int got;
		n = 0;
		got = 0;
		while (n < hi && got == 0) begin
			@(posedge pclk);
			n++;
			if (wdt_reset_req === 1'b1) begin
				got = 1;
			end else if (wake_req === 1'b1) begin
				got = 2;
			end
		end
		check("request kind", got, ev);
		if (ev != 0) begin
			check("request early", n >= lo, 1);
		end
		if (ev != 0 && got == 0) begin
			close_out();
		end
	endtask : run
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_regs();
		apb(1'h0, ADDR_CONTROL, 32'h0);
		check("control reset", rd, {26'h0, PS_RESET, CTL_EN_RESET});
		apb(1'h0, ADDR_STATUS, 32'h0);
		check("flags reset", rd[4:0], 5'h07);
		apb(1'h0, 8'h14, 32'h0);
		check("unmapped error", er, 1'h1);
		apb(1'h1, ADDR_CONTROL, 32'hFFFF_FFFF);
		apb(1'h0, ADDR_CONTROL, 32'h0);
		check("control bits", rd, 32'h3F);
	endtask : s_regs
	task automatic s_modes();
		logic [1:0] md [5] = '{MODE_OFF, MODE_SOFT, MODE_SOFT, MODE_AWAKE, MODE_ON};
		logic [4:0] cd [4] = '{5'h00, 5'h01, 5'h13, 5'h1F};
		int en [5] = '{1, 0, 1, 0, 0};
		int ev [5] = '{0, 0, 1, 1, 1};
		int tk [4] = '{32, 64, 32, 32};
		for (int i = 0; i < 5; i++) begin
			wdt_mode_select <= md[i];
			apb(1'h1, ADDR_CONTROL, 32'(en[i]));
			kick(1'h0);
			run(ev[i], 120, 145);
		end
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, ADDR_CONTROL, {26'h0, cd[i], 1'h0});
			kick(1'h0);
			run(1, tk[i] * 4 - 8, tk[i] * 4 + 17);
		end
	endtask : s_modes
	task automatic s_clear();
		repeat (3) begin
			run(0, 0, 100);
			kick(1'h0);
		end
		run(1, 120, 145);
		osc_fail <= 1'h1;
		run(0, 0, 200);
		osc_fail <= 1'h0;
		run(1, 120, 150);
	endtask : s_clear
	task automatic s_sleep();
		kick(1'h0);
		run(0, 0, 100);
		kick(1'h1);
		run(2, 120, 145);
		repeat (2) @(posedge pclk);
		check("timeout flag", timeout_flag_n, 1'h0);
		check("powerdown flag", powerdown_flag_n, 1'h0);
		check("woken", sleep_active, 1'h0);
		wdt_mode_select <= MODE_AWAKE;
		kick(1'h1);
		run(0, 0, 300);
		check("sleep timeout flag", timeout_flag_n, 1'h1);
		check("sleep powerdown flag", powerdown_flag_n, 1'h0);
		apb(1'h0, ADDR_STATUS, 32'h0);
		check("asleep status", rd[4:0], 5'h11);
		wdt_mode_select <= MODE_SOFT;
		apb(1'h1, ADDR_CONTROL, 32'h1);
		kick(1'h0);
		run(2, 120, 145);
	endtask : s_sleep
	task automatic s_irq();
		apb(1'h1, ADDR_IRQ_MASK, 32'h0);
		apb(1'h1, ADDR_IRQ_STATUS, 32'h7);
		kick(1'h0);
		run(1, 120, 145);
		repeat (2) @(posedge pclk);
		check("reset flag", wdt_reset_flag_n, 1'h0);
		check("irq masked", irq, 1'h0);
		apb(1'h1, ADDR_IRQ_MASK, 32'h1);
		apb(1'h0, ADDR_IRQ_STATUS, 32'h0);
		check("irq raised", irq, 1'h1);
		check("events", rd[2:0], 3'h1);
		apb(1'h1, ADDR_IRQ_STATUS, 32'h1);
		apb(1'h1, ADDR_STATUS, 32'h4);
		check("irq cleared", irq, 1'h0);
		@(posedge pclk);
		check("reset flag back", wdt_reset_flag_n, 1'h1);
	endtask : s_irq
	// main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		s_regs();
		s_modes();
		s_clear();
		s_sleep();
		s_irq();
		close_out();
	end
endmodule : tb
bind wdtm_top wdtm_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_mode_select(wdt_mode_select),
	.sleep_active(sleep_active), .wdt_reset_req(wdt_reset_req), .wake_req(wake_req),
	.timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n), .wdt_reset_flag_n(wdt_reset_flag_n));
